/* File: common/ccgow_pkg.sv */
// constants for the cpu clock generator and oscillator supervision block
// assumes one 50 MHz system clock; the input clock and free-running clock arrive as sampled pins
package ccgow_pkg;
  // selection codes, {bit7,bit6,bit5}
  localparam logic [2:0] SEL_X4 = 3'h7;
  localparam logic [2:0] SEL_X3 = 3'h6;
  localparam logic [2:0] SEL_X2 = 3'h5;
  localparam logic [2:0] SEL_X5 = 3'h4;
  localparam logic [2:0] SEL_DIRECT = 3'h3;
  localparam logic [2:0] SEL_X1P5 = 3'h2;
  localparam logic [2:0] SEL_PRESC = 3'h1;
  localparam logic [2:0] SEL_X2P5 = 3'h0;
  // config bit positions within the port-zero high byte
  localparam int CFG_LSB = 5;
  localparam int CFG_MSB = 7;
  // system configuration register and field
  localparam logic [3:0] ADDR_SYSCFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam int SUP_DIS_BIT = 4;
  localparam logic [15:0] SYSCFG_RST = 16'h0000;
  // supervision overflow count of free clock cycles
  localparam logic [4:0] OVF_COUNT = 5'h10;
  // multiplier numerator/denominator: cpu edges per input transitions, doubled
  // factor F gives 2F cpu half periods per input period; kept as edges per 2 input transitions
  localparam logic [3:0] EDGES_X4 = 4'h8;
  localparam logic [3:0] EDGES_X3 = 4'h6;
  localparam logic [3:0] EDGES_X2 = 4'h4;
  localparam logic [3:0] EDGES_X5 = 4'hA;
  localparam logic [3:0] EDGES_X1P5 = 4'h3;
  localparam logic [3:0] EDGES_X2P5 = 4'h5;
  localparam logic [7:0] PH_ZERO = 8'h00;
  // clock source state
  typedef enum logic [2:0] {
    CCGOW_SRC_INPUT = 3'b001,
    CCGOW_SRC_MULT = 3'b010,
    CCGOW_SRC_FREE = 3'b100
  } ccgow_src_e;
endpackage

/* File: rtl/ccgow_top.sv */
// cpu clock generation with oscillator supervision, modelled as cpu clock edge strobes
// assumes clock_input_pin and free_osc_pin are asynchronous and slow compared with mclk
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module ccgow_top
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] port_zero_high_byte,
  input wire logic clock_input_pin,
  input wire logic free_osc_pin,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_clk,
  output logic cpu_edge,
  output logic multiplier_on,
  output logic osc_fail_interrupt_request,
  output logic [2:0] clk_sel
);
  // three-stage synchronisers for the two external clocks
  logic [2:0] xin_sync_reg, xin_sync_next;
  logic [2:0] fr_sync_reg, fr_sync_next;
  logic xin_level_reg, xin_level_next; // accepted input level
  logic fr_level_reg, fr_level_next;
  logic xin_tr, fr_tr; // accepted transitions
  // configuration: selection latched at reset, system configuration written over the bus
  logic [2:0] sel_reg, sel_next;
  logic [15:0] syscfg_reg, syscfg_next;
  // supervision
  logic [4:0] wd_cnt_reg, wd_cnt_next;
  logic fail_reg, fail_next;
  ccgow_pkg::ccgow_src_e src_reg, src_next;
  // cpu clock generation
  logic cpu_reg, cpu_next;
  logic edge_reg, edge_next;
  logic [3:0] ph_cnt_reg, ph_cnt_next; // multiplier edges since resync
  logic [7:0] ph_acc_reg, ph_acc_next; // mclk ticks accumulated
  logic [7:0] ph_per_reg, ph_per_next; // measured ticks per two input transitions
  logic [7:0] ph_tick_reg, ph_tick_next;
  logic xin_par_reg, xin_par_next;
  // bus
  logic [31:0] rd_reg, rd_next;
  logic wait_reg, wait_next;
  logic sup_en, direct_like;
  // multiplier running flag, registered so the output comes from a flip-flop
  logic mult_on_reg, mult_on_next;
  logic [3:0] edges_tgt;
  logic [7:0] half_ticks;

  // input and free clocks: change counts once stages two and three agree
  always_comb
  begin
    xin_sync_next = {xin_sync_reg[1:0], clock_input_pin};
    fr_sync_next = {fr_sync_reg[1:0], free_osc_pin};
    xin_level_next = (xin_sync_reg[2] == xin_sync_reg[1]) ? xin_sync_reg[2] : xin_level_reg;
    fr_level_next = (fr_sync_reg[2] == fr_sync_reg[1]) ? fr_sync_reg[2] : fr_level_reg;
  end
  assign xin_tr = xin_level_next != xin_level_reg;
  // a glitch shorter than two mclk cycles never reaches the counter
  assign fr_tr = fr_level_next & ~fr_level_reg; // one free clock cycle per rising edge

  // selection: multiplier edges per two input transitions
  always_comb
  begin
    unique case (sel_reg)
      ccgow_pkg::SEL_X4: edges_tgt = ccgow_pkg::EDGES_X4;
      ccgow_pkg::SEL_X3: edges_tgt = ccgow_pkg::EDGES_X3;
      ccgow_pkg::SEL_X2: edges_tgt = ccgow_pkg::EDGES_X2;
      ccgow_pkg::SEL_X5: edges_tgt = ccgow_pkg::EDGES_X5;
      ccgow_pkg::SEL_X1P5: edges_tgt = ccgow_pkg::EDGES_X1P5;
      ccgow_pkg::SEL_X2P5: edges_tgt = ccgow_pkg::EDGES_X2P5;
      default: edges_tgt = ccgow_pkg::EDGES_X2; // direct and prescaler do not use it
    endcase
  end
  // supervision exists only for direct drive or prescaler
  assign direct_like = (sel_reg == ccgow_pkg::SEL_DIRECT) || (sel_reg == ccgow_pkg::SEL_PRESC);
  assign sup_en = direct_like && !syscfg_reg[ccgow_pkg::SUP_DIS_BIT];
  // spacing between multiplier edges, coarse integer division
  assign half_ticks = (edges_tgt == 4'h0) ? ccgow_pkg::PH_ZERO : ph_per_reg / {4'h0, edges_tgt};

  // supervision counter and failure switch-over
  always_comb
  begin
    wd_cnt_next = wd_cnt_reg;
    fail_next = fail_reg; // sticky until reset
    if (!sup_en)
      wd_cnt_next = 5'h00;
    else if (xin_tr)
      wd_cnt_next = 5'h00;
    else if (fr_tr && wd_cnt_reg != ccgow_pkg::OVF_COUNT)
      wd_cnt_next = wd_cnt_reg + 5'h01;
    // counter saturates at overflow so the flag cannot be missed
    if (sup_en && wd_cnt_reg == ccgow_pkg::OVF_COUNT)
      fail_next = 1'b1;
  end

  // source select
  always_comb
  begin
    if (fail_reg)
      src_next = ccgow_pkg::CCGOW_SRC_FREE;
    else if (direct_like)
      src_next = ccgow_pkg::CCGOW_SRC_INPUT;
    else
      src_next = ccgow_pkg::CCGOW_SRC_MULT;
    // multiplier is off only while the source is the input clock with supervision disabled or the fail flag set
    mult_on_next = (src_reg != ccgow_pkg::CCGOW_SRC_INPUT) || (sup_en && !fail_reg);
  end

  // cpu clock: each toggle is one half period
  always_comb
  begin
    cpu_next = cpu_reg;
    edge_next = 1'b0;
    ph_cnt_next = ph_cnt_reg;
    ph_acc_next = ph_acc_reg + 8'h01;
    ph_per_next = ph_per_reg;
    ph_tick_next = ph_tick_reg + 8'h01;
    xin_par_next = xin_par_reg ^ xin_tr;
    unique case (src_reg)
      ccgow_pkg::CCGOW_SRC_FREE:
      begin
        if (fr_level_next != fr_level_reg)
        begin
          cpu_next = fr_level_next;
          edge_next = 1'b1;
        end
      end
      ccgow_pkg::CCGOW_SRC_INPUT:
      begin
        if (sel_reg == ccgow_pkg::SEL_PRESC)
        begin
          if (xin_tr && xin_level_next)
          begin
            cpu_next = ~cpu_reg; // one input period per half period
            edge_next = 1'b1;
          end
        end
        else if (xin_tr)
        begin
          cpu_next = xin_level_next;
          edge_next = 1'b1;
        end
      end
      ccgow_pkg::CCGOW_SRC_MULT:
      begin
        if (xin_tr && xin_par_reg)
        begin
          // resync point: the cpu edge lands on the input transition itself, and the
          // window is re-measured so spacing adapts once per window, never mid-window
          ph_per_next = ph_acc_reg;
          ph_acc_next = 8'h01;
          ph_cnt_next = 4'h1;
          ph_tick_next = 8'h01;
          cpu_next = ~cpu_reg;
          edge_next = 1'b1;
        end
        else if (ph_tick_reg >= half_ticks && ph_cnt_reg < edges_tgt && half_ticks != ccgow_pkg::PH_ZERO)
        begin
          cpu_next = ~cpu_reg;
          edge_next = 1'b1;
          ph_cnt_next = ph_cnt_reg + 4'h1;
          // tick restarts at one so edge spacing equals half_ticks exactly
          ph_tick_next = 8'h01;
        end
      end
      default:
      begin
        cpu_next = cpu_reg;
      end
    endcase
  end

  // register bus: one wait cycle for every access
  always_comb
  begin
    syscfg_next = syscfg_reg;
    rd_next = 32'h0000_0000;
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg)
    begin
      wait_next = 1'b0;
      if (avs_read && avs_address == ccgow_pkg::ADDR_SYSCFG)
        rd_next = {16'h0000, syscfg_reg};
      else if (avs_read && avs_address == ccgow_pkg::ADDR_STATUS)
        rd_next = {25'h0, src_reg, sel_reg, fail_reg};
    end
    // a write lands on the edge where the master sees waitrequest low
    if (avs_write && !wait_reg && avs_address == ccgow_pkg::ADDR_SYSCFG)
      syscfg_next = avs_writedata[15:0];
  end

  // reset-latched selection: no reset value, captured from the strap while reset holds
  always_comb
  begin
    sel_next = sel_reg;
    // captured every reset cycle; the last strap seen before release wins
    if (sys_rst)
      sel_next = port_zero_high_byte[ccgow_pkg::CFG_MSB:ccgow_pkg::CFG_LSB];
  end

  // all state registers
  always_ff @(posedge mclk)
  begin
    sel_reg <= sel_next; // held until next reset
    xin_sync_reg <= xin_sync_next;
    fr_sync_reg <= fr_sync_next;
    if (sys_rst)
    begin
      xin_level_reg <= 1'b0;
      fr_level_reg <= 1'b0;
      syscfg_reg <= ccgow_pkg::SYSCFG_RST;
      wd_cnt_reg <= 5'h00;
      fail_reg <= 1'b0;
      src_reg <= ccgow_pkg::CCGOW_SRC_INPUT;
      cpu_reg <= 1'b0;
      edge_reg <= 1'b0;
      ph_cnt_reg <= 4'h0;
      ph_acc_reg <= 8'h00;
      ph_per_reg <= 8'h00;
      ph_tick_reg <= 8'h00;
      xin_par_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
      mult_on_reg <= 1'b0;
    end
    else
    begin
      xin_level_reg <= xin_level_next;
      fr_level_reg <= fr_level_next;
      syscfg_reg <= syscfg_next;
      wd_cnt_reg <= wd_cnt_next;
      fail_reg <= fail_next;
      src_reg <= src_next;
      cpu_reg <= cpu_next;
      edge_reg <= edge_next;
      ph_cnt_reg <= ph_cnt_next;
      ph_acc_reg <= ph_acc_next;
      ph_per_reg <= ph_per_next;
      ph_tick_reg <= ph_tick_next;
      xin_par_reg <= xin_par_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      mult_on_reg <= mult_on_next;
    end
  end

  // outputs straight from flip-flops
  assign cpu_clk = cpu_reg;
  assign cpu_edge = edge_reg;
  assign osc_fail_interrupt_request = fail_reg;
  assign multiplier_on = mult_on_reg;
  assign clk_sel = sel_reg;
  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;

  // checks: supervision and switch-over first, then clock generation and bus
  // the bench reads the fail flag, the multiplier flag, clk_sel and the status word directly; the rest of this behaviour it sees only through edge counts
  fail_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst) fail_reg |=> fail_reg)
    else $error("fail flag dropped");
  fail_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(fail_reg) |-> $past(wd_cnt_reg) == ccgow_pkg::OVF_COUNT && $past(sup_en))
    else $error("fail without overflow");
  switch_free_a: assert property (@(posedge mclk) disable iff (sys_rst)
    fail_reg |=> src_reg == ccgow_pkg::CCGOW_SRC_FREE)
    else $error("no switch to free clock");
  clear_tr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (sup_en && xin_tr) |=> wd_cnt_reg == 5'h00)
    else $error("counter not cleared");
  dis_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !sup_en |=> wd_cnt_reg == 5'h00 && !$rose(fail_reg))
    else $error("counter ran while disabled");
  sup_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !direct_like |-> wd_cnt_reg == 5'h00 && !fail_reg)
    else $error("supervision outside direct modes");
  sel_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) $stable(sel_reg))
    else $error("selection changed outside reset");
  mult_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sup_en && src_reg == ccgow_pkg::CCGOW_SRC_INPUT) |=> !multiplier_on)
    else $error("multiplier left running");
  // clock generation outside the multiplier follows its source edge for edge, except the prescaler, which toggles on rising input edges only
  direct_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (src_reg == ccgow_pkg::CCGOW_SRC_INPUT && sel_reg == ccgow_pkg::SEL_DIRECT && xin_tr)
    |=> cpu_reg == $past(xin_level_next))
    else $error("direct drive mismatch");
  presc_half_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (src_reg == ccgow_pkg::CCGOW_SRC_INPUT && sel_reg == ccgow_pkg::SEL_PRESC && xin_tr && xin_level_next)
    |=> cpu_reg != $past(cpu_reg))
    else $error("prescaler did not toggle");
  free_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (src_reg == ccgow_pkg::CCGOW_SRC_FREE && fr_level_next != fr_level_reg)
    |=> cpu_reg == $past(fr_level_next))
    else $error("free clock not followed");
  // config writes land only on the accepting edge
  cfg_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (avs_write && !avs_waitrequest && avs_address == ccgow_pkg::ADDR_SYSCFG)
    |=> syscfg_reg == $past(avs_writedata[15:0]))
    else $error("config write lost");
  // main scenarios
  cov_fail_c: cover property (@(posedge mclk) $rose(fail_reg));
  cov_presc_c: cover property (@(posedge mclk) sel_reg == ccgow_pkg::SEL_PRESC && edge_reg);
  cov_mult_c: cover property (@(posedge mclk) src_reg == ccgow_pkg::CCGOW_SRC_MULT && edge_reg);
  cov_dis_c: cover property (@(posedge mclk) direct_like && !sup_en && edge_reg);
endmodule

/* File: verification/ccgow_osc_model.sv */
// behavioural crystal and free-running oscillator in front of the clock block
// assumes mclk is the 50 MHz system clock; both pins change just after its edges
`timescale 1ns/10ps
module ccgow_osc_model
(
  input wire logic mclk,
  input wire logic run,
  input wire logic [3:0] half,
  output logic xtal,
  output logic free_osc
);
  int xc = 0; // input clock phase count
  int fc = 0; // free oscillator phase count
  initial xtal = 1'b0;
  initial free_osc = 1'b0;
  // a dead crystal freezes its pin, which is what supervision must catch
  always @(posedge mclk)
  begin
    xc <= (xc + 1 >= half) ? 0 : xc + 1;
    if (run && xc + 1 >= half)
      xtal <= ~xtal;
    fc <= (fc == 2) ? 0 : fc + 1;
    if (fc == 2)
      free_osc <= ~free_osc;
  end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the cpu clock generator with oscillator supervision
// assumes the avalon slave answers with one cycle of waitrequest low
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] strap = 8'h60; // strap byte
  logic run = 1'b1; // crystal alive
  logic [3:0] hp = 4'h4; // crystal half period in mclk cycles
  logic xtal, free_osc, waitreq, cpu_clk, cpu_edge, mult_on, fail;
  logic [2:0] sel;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  int errors = 0;
  int samples_checked = 0;
  int n, e;
  int exp_e[8] = '{50, 10, 30, 20, 100, 40, 60, 80}; // edges per 20 crystal transitions
  always #10 mclk = ~mclk;
  ccgow_osc_model osc (.mclk(mclk), .run(run), .half(hp), .xtal(xtal), .free_osc(free_osc));
  ccgow_top uut (.mclk(mclk), .sys_rst(sys_rst), .port_zero_high_byte(strap), .clock_input_pin(xtal),
    .free_osc_pin(free_osc), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge),
    .multiplier_on(mult_on), .osc_fail_interrupt_request(fail), .clk_sel(sel));
  // verdict and end of run
  task wrap_up;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // one avalon access; request held until waitrequest seen low
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    rd_en <= ~w;
    wr_en <= w;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (waitreq !== 1'b0 && i < 20);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (waitreq !== 1'b0)
    begin
      errors++;
      wrap_up();
    end
  endtask
  // reset with a strap, then scramble the strap to show it is no longer looked at
  task rst(input logic [7:0] s);
    sys_rst <= 1'b1;
    strap <= s;
    cyc(10);
    sys_rst <= 1'b0;
    strap <= ~s;
    cyc(2);
  endtask
  // count cpu clock edge pulses over k cycles; the count must equal the number of cpu_clk toggles
  task edges(input int k);
    int t;
    logic prev;
    e = 0;
    t = 0;
    prev = cpu_clk;
    repeat (k)
    begin
      @(posedge mclk);
      if (cpu_edge === 1'b1) e++;
      if (cpu_clk !== prev) t++;
      prev = cpu_clk;
    end
    `CHK("clk toggles", e, t)
  endtask
  initial
  begin
    rst(8'h60);
    `CHK("sel", 3'h3, sel)
    bus(4'h1, 1'b0, 32'h0);
    `CHK("status", 32'h16, q)
    bus(4'h0, 1'b0, 32'h0);
    `CHK("cfg", 32'h0, q)
    bus(4'h9, 1'b1, 32'hFFFF);
    bus(4'h9, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("mult", 1'b1, mult_on)
    edges(80);
    `CHK("direct edges", 1'b1, e >= 19 && e <= 21)
    `CHK("no fail", 1'b0, fail)
    bus(4'h0, 1'b1, 32'h10);
    cyc(2);
    `CHK("mult off", 1'b0, mult_on)
    run <= 1'b0;
    cyc(200);
    `CHK("off no fail", 1'b0, fail)
    run <= 1'b1;
    cyc(20);
    bus(4'h0, 1'b1, 32'h0);
    cyc(20);
    run <= 1'b0;
    n = 0;
    while (fail !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    `CHK("fail delay", 1'b1, n >= 85 && n <= 130)
    if (n == 300)
      wrap_up();
    cyc(3);
    bus(4'h1, 1'b0, 32'h0);
    `CHK("status fail", 32'h47, q)
    run <= 1'b1;
    cyc(100);
    bus(4'h1, 1'b0, 32'h0);
    `CHK("stays free", 32'h47, q)
    edges(60);
    `CHK("free edges", 1'b1, e >= 18 && e <= 22)
    // slower crystal so the fastest factor stays below one edge per cycle
    hp <= 4'h8;
    for (int c = 0; c < 8; c++)
    begin
      rst({c[2:0], 5'h00});
      bus(4'h1, 1'b0, 32'h0);
      `CHK("status sel", {((c == 1 || c == 3) ? 3'h1 : 3'h2), c[2:0], 1'b0}, q[6:0])
      `CHK("mult on", 1'b1, mult_on)
      // let two full input periods pass so the rate estimate has settled
      cyc(40);
      edges(160);
      `CHK("edge rate", 1'b1, e >= exp_e[c] - exp_e[c] / 8 - 2 && e <= exp_e[c] + exp_e[c] / 8 + 2)
    end
    run <= 1'b0;
    cyc(200);
    `CHK("pll no watch", 1'b0, fail)
    wrap_up();
  end
endmodule
